// ===== verif/updown_timer_counter_block_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module updown_timer_counter_block_asserts
   import timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic external_count_input,
   input wire logic debug_mode,
   input wire logic [15:0] count_value,
   input wire logic count_up,
   input wire logic max_event,
   input wire logic zero_event
);
   ////////////////////////////////////////////////////////////////////
   // All checks sample on the system clock and rest during reset
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // Bus handshake: one answer cycle per taken request
   a_bus_answer: assert property ((read || write) && waitrequest
      |=> !waitrequest) else $error("no answer after request");
   a_wait_once: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low two cycles");
   a_idle_wait: assert property (!(read || write) |=> waitrequest)
      else $error("answer without request");

   ////////////////////////////////////////////////////////////////////
   // Counter outputs tied to their causes
   a_reset_state: assert property ($fell(reset) |->
      count_value == COUNT_RESET && count_up && !zero_event)
      else $error("bad counter state after reset");
   a_zero_value: assert property (
      zero_event |-> count_value == COUNT_ZERO)
      else $error("zero event with nonzero count");
   a_zero_pulse: assert property (zero_event |=> !zero_event)
      else $error("zero event longer than one cycle");
   a_count_step: assert property (
      $changed(count_value) && count_value != COUNT_ZERO && !max_event
      && !$past(write) && !$past(write, 2) |-> count_value == (count_up ?
      $past(count_value) + COUNT_ONE : $past(count_value) - COUNT_ONE))
      else $error("counter step not one in its direction");
   a_status_dir: assert property (
      read && waitrequest && address == OFS_STATUS
      |=> readdata[STS_UP_BIT] == $past(count_up))
      else $error("status direction differs from count_up");
   a_count_read: assert property (
      read && waitrequest && address == OFS_COUNT
      |=> readdata == {16'h0000, $past(count_value)})
      else $error("count readback differs from counter");
endmodule
bind updown_timer_counter_block updown_timer_counter_block_asserts
   updown_timer_counter_block_asserts_inst (.clk_sys, .reset, .address,
   .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
   .external_count_input, .debug_mode, .count_value, .count_up,
   .max_event, .zero_event);
`default_nettype wire

// ===== verif/updown_timer_counter_block_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module updown_timer_counter_block_bench
   import timer_pkg::*;
();
   typedef struct {
      logic [1:0] m;
      logic s;
      logic [15:0] lim;
      int steps;
      logic [15:0] fin;
      logic busy;
   } case_s;
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   logic [4:0] address = 5'h00;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic ext_in = 1'h0;
   logic debug_mode = 1'h0;
   logic [31:0] readdata, rd;
   logic waitrequest, count_up, max_event, zero_event;
   logic [15:0] count_value;
   int fail_count = 0;
   int n_checks = 0;
   // Mode, single pass, limit, steps, final count, busy after
   case_s rows [7] = '{'{2'h0, 1'h0, 16'h2, 7, 16'h1, 1'h1},
      '{2'h0, 1'h1, 16'h3, 4, 16'h0, 1'h0},
      '{2'h1, 1'h0, 16'h2, 6, 16'h2, 1'h1},
      '{2'h1, 1'h1, 16'h2, 3, 16'h2, 1'h0},
      '{2'h2, 1'h0, 16'h2, 7, 16'h1, 1'h1},
      '{2'h2, 1'h1, 16'h2, 4, 16'h0, 1'h0},
      '{2'h3, 1'h0, 16'h1, 3, 16'h1, 1'h1}};

   ////////////////////////////////////////////////////////////////////
   // Clock and device
   always #4 clk_sys = ~clk_sys;

   updown_timer_counter_block updown_timer_counter_block_inst (.clk_sys,
      .reset, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .external_count_input(ext_in), .debug_mode,
      .count_value, .count_up, .max_event, .zero_event);

   ////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task report_and_stop;
      $display("checks %0d failures %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Avalon access held until waitrequest is sampled low
   task automatic bus(input logic wr_n, input logic [4:0] a,
      input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !wr_n;
      write <= wr_n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (waitrequest !== 1'h0 && n < 50);
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
      if (n >= 50) begin
         fail_count++;
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'h1, a, d, 4'hf);
   endtask

   task automatic rdr(input logic [4:0] a);
      bus(1'h0, a, 32'h0, 4'hf);
   endtask

   // Wait, bounded, for the next counter change
   task automatic next_val(output logic [15:0] v);
      int n;
      logic [15:0] last;
      last = count_value;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (count_value === last && n < 100);
      if (n >= 100) begin
         fail_count++;
         report_and_stop();
      end
      v = count_value;
   endtask

   task automatic hold(input string nm);
      logic [15:0] h;
      h = count_value;
      repeat (40) @(posedge clk_sys);
      `CHK(nm, h, count_value)
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_sys) ext_in <= 1'h1;
         repeat (10) @(posedge clk_sys);
         ext_in <= 1'h0;
         repeat (10) @(posedge clk_sys);
      end
   endtask

   function automatic logic [31:0] ctl(logic [1:0] m, logic s, logic p,
      logic r);
      logic [31:0] v;
      v = 32'h0;
      v[CTL_ENABLE_BIT] = 1'h1;
      v[CTL_PRESET_BIT] = p;
      v[CTL_RUN_BIT] = r;
      v[CTL_MODE_LSB +: 2] = m;
      v[CTL_SINGLE_BIT] = s;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Main sequence: reset, mode table, then awkward cases
   initial begin
      case_s r;
      logic [15:0] c, v;
      logic up;
      int n;
      repeat (8) @(posedge clk_sys);
      reset <= 1'h0;
      @(posedge clk_sys);
      `CHK("up_rst", 1'h1, count_up)
      rdr(OFS_LIMIT);
      `CHK("limit_rst", {16'h0, LIMIT_RESET}, rd)
      rdr(5'h14);
      `CHK("unmapped", 32'h0, rd)
      wr(OFS_COUNT, 32'h1234);
      wr(OFS_CLOCK, 32'h30);
      for (int i = 0; i < 7; i++) begin
         r = rows[i];
         wr(OFS_CONTROL, 32'h0);
         wr(OFS_LIMIT, {16'h0, r.lim});
         wr(OFS_CONTROL, ctl(r.m, r.s, 1'h1, 1'h0));
         repeat (2) @(posedge clk_sys);
         c = (r.m == DIR_DOWN) ? r.lim : 16'h0;
         `CHK("preset", c, count_value)
         wr(OFS_CONTROL, ctl(r.m, r.s, 1'h0, 1'h1));
         up = 1'h1;
         for (int k = 0; k < r.steps; k++) begin
            // Direction flips on the step that leaves an end point, or on reaching zero in single pass
            if (r.m == DIR_UPDOWN) begin
               if (c == r.lim) up = 1'h0;
               else if (c == 16'h0) up = 1'h1;
               c = up ? c + 16'h1 : c - 16'h1;
               if (r.s && c == 16'h0) up = 1'h1;
            end else if (r.m == DIR_DOWN) begin
               c = (c == 16'h0) ? r.lim : c - 16'h1;
            end else begin
               c = (c >= r.lim) ? 16'h0 : c + 16'h1;
            end
            next_val(v);
            `CHK("count", c, v)
            `CHK("events", {c == r.lim, c == 16'h0}, {max_event, zero_event})
            `CHK("dir", (r.m != DIR_DOWN) && up, count_up)
         end
         if (r.s) hold("stopped");
         `CHK("final", r.fin, count_value)
         rdr(OFS_STATUS);
         `CHK("busy", r.busy, rd[STS_BUSY_BIT])
      end
      // Limit cut below the running count
      wr(OFS_LIMIT, 32'h20);
      wr(OFS_CONTROL, ctl(DIR_UP, 1'h0, 1'h1, 1'h1));
      n = 0;
      while (count_value !== 16'h0005 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      bus(1'h1, OFS_LIMIT, 32'hff03, 4'h1);
      next_val(v);
      `CHK("shrink", 16'h0000, v)
      rdr(OFS_LIMIT);
      `CHK("limit_be", 32'h3, rd)
      rdr(OFS_CONTROL);
      `CHK("pending", 1'h0, rd[CTL_PENDING_BIT])
      // Hold with enable low, then with run low
      wr(OFS_CONTROL, 32'h4);
      hold("hold_off");
      wr(OFS_CONTROL, 32'h1);
      hold("hold_stop");
      // Debug halt, then keep running in debug
      wr(OFS_CONTROL, ctl(DIR_UP, 1'h0, 1'h0, 1'h1));
      @(posedge clk_sys) debug_mode <= 1'h1;
      hold("hold_dbg");
      c = (count_value >= 16'h3) ? 16'h0 : count_value + 16'h1;
      wr(OFS_CLOCK, 32'h130);
      next_val(v);
      `CHK("dbg_run", c, v)
      @(posedge clk_sys) debug_mode <= 1'h0;
      // Pin source, rising then falling edges
      wr(OFS_CLOCK, 32'h1);
      wr(OFS_LIMIT, 32'hffff);
      wr(OFS_CONTROL, ctl(DIR_UP, 1'h0, 1'h1, 1'h1));
      pulse(3);
      `CHK("rise", 16'h3, count_value)
      wr(OFS_CLOCK, 32'h2);
      pulse(2);
      `CHK("fall", 16'h5, count_value)
      report_and_stop();
   end
endmodule
`default_nettype wire

// ===== verilog/count_tick.sv
`timescale 1ns/1ps
`default_nettype none
module count_tick
   import timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire count_cfg_s cfg,
   input wire logic external_count_input,
   input wire logic debug_mode,
   output logic tick
);

   typedef struct packed {
      logic [2:0] sync;
      logic level;
      logic [14:0] prescale;
      logic tick;
   } tick_state_s;

   tick_state_s st_r;
   tick_state_s st_nxt;
   logic [14:0] mask;
   logic halted;
   logic pin_rise;
   logic pin_fall;

   // Prescaler tap mask, ratio is two to the power of divide
   assign mask = 15'((16'h0001 << cfg.divide) - 16'h0001);
   assign halted = debug_mode & ~cfg.debug_keep_running; // see RL22
   assign pin_rise = (st_r.sync[1] == st_r.sync[2]) &
                     st_r.sync[2] & ~st_r.level;
   assign pin_fall = (st_r.sync[1] == st_r.sync[2]) &
                     ~st_r.sync[2] & st_r.level;

   // Pin filter, prescaler and count tick selection
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync = {st_r.sync[1:0], external_count_input};
      if (st_r.sync[1] == st_r.sync[2]) begin
         st_nxt.level = st_r.sync[2];
      end
      st_nxt.tick = 1'b0;
      if (!halted) begin
         st_nxt.prescale = st_r.prescale + 15'h0001;
         case (cfg.source)
            SRC_INTERNAL: st_nxt.tick = (st_r.prescale & mask) == mask;
            SRC_PIN_RISE: st_nxt.tick = pin_rise; // see RL21
            SRC_PIN_FALL: st_nxt.tick = pin_fall; // see RL21
            default: st_nxt.tick = 1'b0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

endmodule
`default_nettype wire

// ===== verilog/timer_pkg.sv
package timer_pkg;

   // Register byte offsets
   localparam logic [4:0] OFS_CLOCK = 5'h00;
   localparam logic [4:0] OFS_CONTROL = 5'h04;
   localparam logic [4:0] OFS_LIMIT = 5'h08;
   localparam logic [4:0] OFS_COUNT = 5'h0c;
   localparam logic [4:0] OFS_STATUS = 5'h10;

   // Clock register fields
   localparam int CLK_SRC_LSB = 0;
   localparam int CLK_DIV_LSB = 4;
   localparam int CLK_DBG_BIT = 8;

   // Control register fields
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_PRESET_BIT = 1;
   localparam int CTL_RUN_BIT = 2;
   localparam int CTL_MODE_LSB = 4;
   localparam int CTL_SINGLE_BIT = 6;
   localparam int CTL_PENDING_BIT = 8;

   // Status register fields
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_UP_BIT = 1;

   // Reset values and count constants
   localparam logic [15:0] LIMIT_RESET = 16'hffff;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   // Count clock sources
   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'h0,
      SRC_PIN_RISE = 2'h1,
      SRC_PIN_FALL = 2'h2,
      SRC_OFF = 2'h3
   } count_source_e;

   // Direction modes
   typedef enum logic [1:0] {
      DIR_UP = 2'h0,
      DIR_DOWN = 2'h1,
      DIR_UPDOWN = 2'h2,
      DIR_SPARE = 2'h3
   } direction_mode_e;

   // Phase of the up/down walk
   typedef enum logic {
      PH_UP,
      PH_DOWN
   } phase_e;

   // Count clock configuration
   typedef struct packed {
      count_source_e source;
      logic [3:0] divide;
      logic debug_keep_running;
   } count_cfg_s;

endpackage

// ===== verilog/updown_timer_counter_block.sv
`timescale 1ns/1ps
`default_nettype none
//Contract
// RL1: 16-bit counter steps once per count tick
// RL2: Mode field plus single-pass bit give six modes
// RL3: Counter stays within zero to limit
// RL4: Software waits for pending flag before limit write
// RL5: Software rewrites limit after counter wraps
// RL6: Preset clears, or loads limit in down mode
// RL7: Upward count past limit clears to zero
// RL8: Run bit starts counting
// RL9: Software reads count twice or stops first
// RL10: Busy status reads one while running
// RL11: Direction status reads one counting up
// RL12: Repeat up wraps and continues until run cleared
// RL13: Limit below count clears counter first; code clears it only while counting up
// RL14: Single-pass up wraps to zero then stops
// RL15: Repeat down reloads limit on underflow
// RL16: Single-pass down reloads limit then stops
// RL17: Up/down repeats, new limit after zero; code applies a staged limit at the next tick
// RL18: Single-pass up/down stops at zero descending
// RL19: Software orders comparator setup before run
// RL20: Software orders capture setup before run
// RL21: Pin source counts rising, inverted counts falling
// RL22: Debug halts counting unless keep-running set
// RL23: Automatic stop clears run and busy
// RL24: Counter holds while run or enable low
module updown_timer_counter_block
   import timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic external_count_input,
   input wire logic debug_mode,
   output logic [15:0] count_value,
   output logic count_up,
   output logic max_event,
   output logic zero_event
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
      count_cfg_s cfg;
      logic module_enable;
      logic run;
      direction_mode_e mode;
      logic single_pass_select;
      logic [15:0] limit_value;
      logic [15:0] active_limit;
      logic limit_write_pending;
      logic [15:0] count;
      phase_e phase;
      logic max_event;
      logic zero_event;
   } block_state_s;

   block_state_s st_r;
   block_state_s st_nxt;
   logic tick;
   logic access;
   logic wr_take;
   logic [31:0] clock_image;
   logic [31:0] control_image;
   logic [31:0] status_image;
   logic [31:0] wr_clock;
   logic [31:0] wr_control;
   logic [31:0] wr_limit;
   logic counting;
   logic [15:0] lim;

   // Merge write data into a register image under byte enables
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Count clock

   count_tick u_tick (
      .clk_sys(clk_sys),
      .reset(reset),
      .cfg(st_r.cfg),
      .external_count_input(external_count_input),
      .debug_mode(debug_mode),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register images

   // Readable views of the registers
   always_comb begin
      clock_image = '0;
      clock_image[CLK_SRC_LSB +: 2] = st_r.cfg.source;
      clock_image[CLK_DIV_LSB +: 4] = st_r.cfg.divide;
      clock_image[CLK_DBG_BIT] = st_r.cfg.debug_keep_running;
      control_image = '0;
      control_image[CTL_ENABLE_BIT] = st_r.module_enable;
      control_image[CTL_RUN_BIT] = st_r.run;
      control_image[CTL_MODE_LSB +: 2] = st_r.mode;
      control_image[CTL_SINGLE_BIT] = st_r.single_pass_select;
      control_image[CTL_PENDING_BIT] = st_r.limit_write_pending;
      status_image = '0;
      status_image[STS_BUSY_BIT] = st_r.run; // see RL10
      status_image[STS_UP_BIT] = (st_r.phase == PH_UP); // see RL11
   end

   // Bus handshake, one wait state per access
   assign access = read | write;
   assign wr_take = write & ~st_r.waitrequest;
   assign wr_clock = merge_bytes(clock_image, writedata, byteenable);
   assign wr_control = merge_bytes(control_image, writedata, byteenable);
   assign wr_limit = merge_bytes({16'h0000, st_r.limit_value}, writedata,
                                 byteenable);
   assign counting = st_r.module_enable & st_r.run; // see RL24
   // A staged limit is seen by the engine on the tick that applies it
   assign lim = st_r.limit_write_pending ? st_r.limit_value :
                st_r.active_limit; // see RL13

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt = st_r;
      st_nxt.max_event = 1'b0;
      st_nxt.zero_event = 1'b0;
      st_nxt.waitrequest = ~(access & st_r.waitrequest);

      // Read data captured while the request waits
      if (read & st_r.waitrequest) begin
         case (address)
            OFS_CLOCK: st_nxt.readdata = clock_image;
            OFS_CONTROL: st_nxt.readdata = control_image;
            OFS_LIMIT: st_nxt.readdata = {16'h0000, st_r.limit_value};
            OFS_COUNT: st_nxt.readdata = {16'h0000, st_r.count}; // see RL9
            OFS_STATUS: st_nxt.readdata = status_image;
            default: st_nxt.readdata = '0;
         endcase
      end

      // Limit staging is applied at the next tick or at once when idle
      if (st_r.limit_write_pending && (tick || !counting)) begin
         st_nxt.active_limit = st_r.limit_value;
         st_nxt.limit_write_pending = 1'b0;
      end

      // Counter engine
      if (counting && tick) begin
         case (st_r.mode)
            DIR_DOWN: begin
               st_nxt.phase = PH_DOWN;
               if (st_r.count == COUNT_ZERO) begin
                  st_nxt.count = lim; // see RL15
                  st_nxt.max_event = 1'b1;
                  if (st_r.single_pass_select) begin
                     st_nxt.run = 1'b0; // see RL16
                  end
               end else begin
                  st_nxt.count = st_r.count - COUNT_ONE; // see RL1
                  st_nxt.zero_event = (st_r.count == COUNT_ONE);
               end
            end
            DIR_UPDOWN: begin
               if (st_r.phase == PH_UP) begin
                  if (st_r.count > lim) begin
                     st_nxt.count = COUNT_ZERO; // see RL13
                     st_nxt.zero_event = 1'b1;
                  end else if (st_r.count == lim) begin
                     st_nxt.phase = PH_DOWN; // see RL17
                     if (lim != COUNT_ZERO) begin
                        st_nxt.count = st_r.count - COUNT_ONE;
                     end
                     st_nxt.zero_event = (st_r.count == COUNT_ONE);
                  end else begin
                     st_nxt.count = st_r.count + COUNT_ONE;
                     st_nxt.max_event = (st_r.count + COUNT_ONE) == lim;
                  end
               end else if (st_r.count == COUNT_ZERO) begin
                  st_nxt.phase = PH_UP; // see RL17
                  if (lim != COUNT_ZERO) begin
                     st_nxt.count = COUNT_ONE;
                  end
                  st_nxt.max_event = (lim == COUNT_ONE);
               end else begin
                  st_nxt.count = st_r.count - COUNT_ONE;
                  if (st_r.count == COUNT_ONE) begin
                     st_nxt.zero_event = 1'b1;
                     if (st_r.single_pass_select) begin
                        st_nxt.run = 1'b0; // see RL18
                        st_nxt.phase = PH_UP;
                     end
                  end
               end
            end
            default: begin
               st_nxt.phase = PH_UP;
               if (st_r.count >= lim) begin
                  st_nxt.count = COUNT_ZERO; // see RL7
                  st_nxt.zero_event = 1'b1;
                  if (st_r.single_pass_select) begin
                     st_nxt.run = 1'b0; // see RL14 RL23
                  end
               end else begin
                  st_nxt.count = st_r.count + COUNT_ONE; // see RL12
                  st_nxt.max_event = (st_r.count + COUNT_ONE) == lim;
               end
            end
         endcase
      end

      // Register writes, a software write beats the automatic stop
      if (wr_take) begin
         case (address)
            OFS_CLOCK: begin
               st_nxt.cfg.source = count_source_e'(wr_clock[CLK_SRC_LSB +: 2]);
               st_nxt.cfg.divide = wr_clock[CLK_DIV_LSB +: 4];
               st_nxt.cfg.debug_keep_running = wr_clock[CLK_DBG_BIT];
            end
            OFS_CONTROL: begin
               st_nxt.module_enable = wr_control[CTL_ENABLE_BIT];
               st_nxt.run = wr_control[CTL_RUN_BIT]; // see RL8
               st_nxt.mode =
                  direction_mode_e'(wr_control[CTL_MODE_LSB +: 2]); // see RL2
               st_nxt.single_pass_select = wr_control[CTL_SINGLE_BIT];
               if (wr_control[CTL_PRESET_BIT]) begin
                  st_nxt.active_limit = st_r.limit_value;
                  st_nxt.limit_write_pending = 1'b0;
                  if (direction_mode_e'(wr_control[CTL_MODE_LSB +: 2])
                      == DIR_DOWN) begin
                     st_nxt.count = st_r.limit_value; // see RL6
                     st_nxt.phase = PH_DOWN;
                  end else begin
                     st_nxt.count = COUNT_ZERO; // see RL6
                     st_nxt.phase = PH_UP;
                  end
               end
            end
            OFS_LIMIT: begin
               st_nxt.limit_value = wr_limit[15:0]; // see RL3
               st_nxt.limit_write_pending = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r <= '0;
         st_r.waitrequest <= 1'b1;
         st_r.limit_value <= LIMIT_RESET;
         st_r.active_limit <= LIMIT_RESET;
         st_r.count <= COUNT_RESET;
         st_r.phase <= PH_UP;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign readdata = st_r.readdata;
   assign waitrequest = st_r.waitrequest;
   assign count_value = st_r.count;
   assign count_up = (st_r.phase == PH_UP);
   assign max_event = st_r.max_event;
   assign zero_event = st_r.zero_event;

endmodule
`default_nettype wire
